// ==== verilog/irq_enable_defines.svh ====
// Purpose: Constants for the interrupt enable mask register block.
// Assumes: 8-bit special-function-register bus, 100 MHz clock.
// Notes: Included by the package and the interrupt_enable_mask module.
//
// Functional notes
// R1: Bit 7 is the global enable; when it is 0 no request is forwarded, and it overrides every mask.
// R2: Bit 6 masks all SPI port 0 requests, 0 blocks and 1 passes.
// R3: Bit 5 masks timer 2, whose request is the OR of its low-byte and high-byte overflow flags.
// R4: Bit 4 masks the UART 0 request, 0 blocks and 1 passes.
// R5: Bit 3 masks timer 1, so a set timer 1 overflow flag raises a request only when it is 1.
// R6: Bit 2 masks external interrupt 1, forwarding its input only when it is 1.
// R7: Bit 1 masks timer 0, so a set timer 0 overflow flag raises a request only when it is 1.
// R8: Bit 0 masks external interrupt 0, forwarding its input only when it is 1.
// R9: The register sits at address 0xA8 on every page, is bit addressable, all bits read/write, reset 0.
// R10: Masking only gates the request; source flags are untouched, so requests appear when unmasked.
`ifndef IRQ_ENABLE_DEFINES_SVH
`define IRQ_ENABLE_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define IEM_ADDR 8'hA8
`define IEM_RESET 8'h00
`define IEM_BIT_BYTE_ADDR 5'h15
`define IEM_NUM_SRC 7
`define IEM_RD_IDLE 8'h00
`define IEM_BIT_BYTE_MSB 7
`define IEM_BIT_BYTE_LSB 3
`define IEM_BIT_IDX_MSB 2

// ****************************************************************
// Field positions
// ****************************************************************
`define IEM_GLOBAL_BIT 7
`define IEM_SPI0_BIT 6
`define IEM_TIMER2_BIT 5
`define IEM_UART0_BIT 4
`define IEM_TIMER1_BIT 3
`define IEM_EXT1_BIT 2
`define IEM_TIMER0_BIT 1
`define IEM_EXT0_BIT 0

`endif

// ==== verilog/irq_enable_pkg.sv ====
// Purpose: Types shared by the interrupt enable mask block.
// Assumes: The defines header supplies all numbers.
// Notes: Source vector order follows the register bit order 6..0.
`include "irq_enable_defines.svh"

package irq_enable_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef logic [`IEM_NUM_SRC-1:0] src_vec_t;
endpackage

// ==== verilog/pin_sync.sv ====
// Purpose: Two-flop synchroniser for a group of asynchronous inputs.
// Assumes: One clock, synchronous active-high reset.
// Notes: The first stage is read only by the second stage.
module pin_sync (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic [1:0] async_in, // Pin levels.
  output logic [1:0] sync_out // Synchronised levels.
);
  logic [1:0] meta_ff;

  // Two stages guard against metastability on the external pins.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_ff <= 2'h0;
      sync_out <= 2'h0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

// ==== verilog/interrupt_enable_mask.sv ====
// Purpose: Interrupt enable register with global and per-source gating of requests.
// Assumes: Core SFR bus with byte and bit-addressed writes, one 100 MHz clock.
// Notes: Request outputs lag a source flag by one cycle; external inputs by three.
`include "irq_enable_defines.svh"

module interrupt_enable_mask (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic sfr_wr, // Byte write strobe.
  input wire logic sfr_rd, // Byte read strobe.
  input wire logic [7:0] sfr_addr, // Byte address.
  input wire irq_enable_pkg::sfr_byte_t sfr_wdata, // Write data.
  output irq_enable_pkg::sfr_byte_t sfr_rdata, // Read data, registered.
  input wire logic bit_wr, // Single-bit write strobe.
  input wire logic [7:0] bit_addr, // Bit address: byte in 7:3, bit in 2:0.
  input wire logic bit_wdata, // Bit value to write.
  output irq_enable_pkg::sfr_byte_t irq_enable_mask, // Register contents.
  input wire logic spi_port0_irq_flag, // SPI port 0 pending flag.
  input wire logic timer2_low_overflow_flag, // Timer 2 low-byte overflow.
  input wire logic timer2_high_overflow_flag, // Timer 2 high-byte overflow.
  input wire logic uart_port0_irq_flag, // UART 0 pending flag.
  input wire logic timer1_overflow_flag, // Timer 1 overflow.
  input wire logic timer0_overflow_flag, // Timer 0 overflow.
  input wire logic external_request1_input, // External request 1 pin.
  input wire logic external_request0_input, // External request 0 pin.
  output irq_enable_pkg::src_vec_t irq_req, // Gated requests to the core, bits 6..0.
  output logic irq_any // Any gated request pending.
);
  import irq_enable_pkg::*;

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [1:0] ext_sync;

  pin_sync u_pin_sync (
    .clk(clk),
    .srst(srst),
    .async_in({external_request1_input, external_request0_input}),
    .sync_out(ext_sync)
  );

  // ****************************************************************
  // Register
  // ****************************************************************
  sfr_byte_t iem_ff;
  logic byte_hit;
  logic bit_hit;

  // Page register is ignored on purpose, so the address decodes on every page.
  assign byte_hit = (sfr_addr == `IEM_ADDR); // R9
  assign bit_hit = bit_wr && (bit_addr[`IEM_BIT_BYTE_MSB:`IEM_BIT_BYTE_LSB] == `IEM_BIT_BYTE_ADDR); // R9

  // Byte write wins over a bit write in the same cycle; the core never issues both.
  always_ff @(posedge clk)
  begin
    if (srst)
      iem_ff <= `IEM_RESET; // R9
    else if (sfr_wr && byte_hit)
      iem_ff <= sfr_wdata; // R9
    else if (bit_hit)
      iem_ff[bit_addr[`IEM_BIT_IDX_MSB:0]] <= bit_wdata; // R9
  end

  // Read data is registered; unmapped addresses read zero.
  always_ff @(posedge clk)
  begin
    if (srst)
      sfr_rdata <= `IEM_RD_IDLE;
    else if (sfr_rd && byte_hit)
      sfr_rdata <= iem_ff;
    else
      sfr_rdata <= `IEM_RD_IDLE;
  end

  // Registered copy of the register, so every top-level output leaves a flip-flop.
  always_ff @(posedge clk)
  begin
    if (srst)
      irq_enable_mask <= `IEM_RESET;
    else
      irq_enable_mask <= iem_ff;
  end

  // ****************************************************************
  // Request gating
  // ****************************************************************
  src_vec_t src_raw;
  src_vec_t src_en;
  src_vec_t nxt_req;

  // Sources are only read, never cleared, so a masked flag survives to be seen later.
  assign src_raw = {spi_port0_irq_flag, // R2
                    timer2_low_overflow_flag | timer2_high_overflow_flag, // R3
                    uart_port0_irq_flag, // R4
                    timer1_overflow_flag, // R5
                    ext_sync[1], // R6
                    timer0_overflow_flag, // R7
                    ext_sync[0]}; // R8 R10
  assign src_en = iem_ff[`IEM_SPI0_BIT:`IEM_EXT0_BIT];

  // One gate per source; the global bit dominates every mask.
  genvar gi;
  generate
    for (gi = 0; gi < `IEM_NUM_SRC; gi = gi + 1)
    begin : g_gate
      assign nxt_req[gi] = iem_ff[`IEM_GLOBAL_BIT] & src_en[gi] & src_raw[gi]; // R1 R10
    end
  endgenerate

  // Registering the requests costs one cycle but keeps the core's inputs glitch free.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      irq_req <= '0;
      irq_any <= 1'b0;
    end
    else
    begin
      irq_req <= nxt_req; // R1
      irq_any <= |nxt_req; // R1
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Every property samples on the system clock; all but p_reset are quiet while reset is applied.
  property p_global_off;
    @(posedge clk) disable iff (srst)
      !$past(iem_ff[`IEM_GLOBAL_BIT]) && !$past(srst) |-> (irq_req == '0) && !irq_any;
  endproperty
  a_global_off: assert property (p_global_off) else $error("Request with global enable off"); // R1

  property p_spi;
    @(posedge clk) disable iff (srst)
      !$past(srst) |-> irq_req[`IEM_SPI0_BIT] ==
        ($past(iem_ff[`IEM_GLOBAL_BIT]) & $past(iem_ff[`IEM_SPI0_BIT]) & $past(spi_port0_irq_flag));
  endproperty
  a_spi: assert property (p_spi) else $error("SPI 0 request mismatch"); // R2

  property p_timer2;
    @(posedge clk) disable iff (srst)
      iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_TIMER2_BIT]
        && (timer2_low_overflow_flag || timer2_high_overflow_flag)
        |=> irq_req[`IEM_TIMER2_BIT];
  endproperty
  a_timer2: assert property (p_timer2) else $error("Timer 2 request missing"); // R3

  property p_uart;
    @(posedge clk) disable iff (srst)
      !iem_ff[`IEM_UART0_BIT] |=> !irq_req[`IEM_UART0_BIT];
  endproperty
  a_uart: assert property (p_uart) else $error("UART 0 request while masked"); // R4

  property p_timer1;
    @(posedge clk) disable iff (srst)
      iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_TIMER1_BIT] && timer1_overflow_flag
        |=> irq_req[`IEM_TIMER1_BIT];
  endproperty
  a_timer1: assert property (p_timer1) else $error("Timer 1 request missing"); // R5

  property p_ext1;
    @(posedge clk) disable iff (srst)
      iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_EXT1_BIT] && external_request1_input
        ##1 external_request1_input
        ##1 external_request1_input && iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_EXT1_BIT]
        |=> irq_req[`IEM_EXT1_BIT];
  endproperty
  a_ext1: assert property (p_ext1) else $error("External 1 request missing"); // R6

  property p_timer0;
    @(posedge clk) disable iff (srst)
      !iem_ff[`IEM_TIMER0_BIT] |=> !irq_req[`IEM_TIMER0_BIT];
  endproperty
  a_timer0: assert property (p_timer0) else $error("Timer 0 request while masked"); // R7

  property p_ext0;
    @(posedge clk) disable iff (srst)
      !iem_ff[`IEM_EXT0_BIT] |=> !irq_req[`IEM_EXT0_BIT];
  endproperty
  a_ext0: assert property (p_ext0) else $error("External 0 request while masked"); // R8

  property p_write;
    @(posedge clk) disable iff (srst)
      sfr_wr && (sfr_addr == `IEM_ADDR) |=> iem_ff == $past(sfr_wdata) ##1
        irq_enable_mask == $past(iem_ff);
  endproperty
  a_write: assert property (p_write) else $error("Register byte write lost"); // R9

  property p_unmask;
    @(posedge clk) disable iff (srst)
      iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_UART0_BIT] && uart_port0_irq_flag
        |=> irq_req[`IEM_UART0_BIT];
  endproperty
  a_unmask: assert property (p_unmask) else $error("Held flag not forwarded when unmasked"); // R10

  property p_read;
    @(posedge clk) disable iff (srst)
      sfr_rd && (sfr_addr == `IEM_ADDR) |=> sfr_rdata == $past(iem_ff);
  endproperty
  a_read: assert property (p_read) else $error("Register read data wrong"); // R9

  property p_read_idle;
    @(posedge clk) disable iff (srst)
      !(sfr_rd && (sfr_addr == `IEM_ADDR)) |=> sfr_rdata == `IEM_RD_IDLE;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("Read data not idle"); // R9

  property p_bit_write;
    @(posedge clk) disable iff (srst)
      bit_wr && !sfr_wr
        && (bit_addr[`IEM_BIT_BYTE_MSB:`IEM_BIT_BYTE_LSB] == `IEM_BIT_BYTE_ADDR)
        |=> iem_ff[$past(bit_addr[`IEM_BIT_IDX_MSB:0])] == $past(bit_wdata);
  endproperty
  a_bit_write: assert property (p_bit_write) else $error("Register bit write lost"); // R9

  property p_reset;
    @(posedge clk)
      srst |=> (iem_ff == `IEM_RESET) && (irq_req == '0) && !irq_any;
  endproperty
  a_reset: assert property (p_reset) else $error("Reset state wrong"); // R9

  property p_timer0_fwd;
    @(posedge clk) disable iff (srst)
      iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_TIMER0_BIT] && timer0_overflow_flag
        |=> irq_req[`IEM_TIMER0_BIT];
  endproperty
  a_timer0_fwd: assert property (p_timer0_fwd) else $error("Timer 0 request missing"); // R7

  property p_ext0_fwd;
    @(posedge clk) disable iff (srst)
      iem_ff[`IEM_GLOBAL_BIT] && iem_ff[`IEM_EXT0_BIT] && ext_sync[0]
        |=> irq_req[`IEM_EXT0_BIT];
  endproperty
  a_ext0_fwd: assert property (p_ext0_fwd) else $error("External 0 request missing"); // R8

  property p_timer2_mask;
    @(posedge clk) disable iff (srst)
      !iem_ff[`IEM_TIMER2_BIT] |=> !irq_req[`IEM_TIMER2_BIT];
  endproperty
  a_timer2_mask: assert property (p_timer2_mask) else $error("Timer 2 request while masked"); // R3

  property p_timer1_mask;
    @(posedge clk) disable iff (srst)
      !iem_ff[`IEM_TIMER1_BIT] |=> !irq_req[`IEM_TIMER1_BIT];
  endproperty
  a_timer1_mask: assert property (p_timer1_mask) else $error("Timer 1 request while masked"); // R5

  property p_ext1_mask;
    @(posedge clk) disable iff (srst)
      !iem_ff[`IEM_EXT1_BIT] |=> !irq_req[`IEM_EXT1_BIT];
  endproperty
  a_ext1_mask: assert property (p_ext1_mask) else $error("External 1 request while masked"); // R6
endmodule

// ==== bench/irq_source_model.sv ====
// Purpose: Model of the peripheral pending flags and external pins that feed the mask block.
// Assumes: One clock; only the owner of a flag sets or clears it.
// Notes: Bits 7..0 are SPI0, timer2 low, timer2 high, UART0, timer1, timer0, ext1, ext0.
module irq_source_model (
  input wire logic clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic [7:0] set_vec, // Flags to raise.
  input wire logic [7:0] clr_vec, // Flags to drop.
  output logic [7:0] flags_ff // Pending levels.
);
  timeunit 1ns;
  timeprecision 1ps;
  // A flag stays up until its owner drops it, so a masked request is never lost.
  always_ff @(posedge clk)
  begin
    if (srst)
      flags_ff <= 8'h00;
    else
      flags_ff <= (flags_ff | set_vec) & ~clr_vec;
  end
endmodule

// ==== bench/interrupt_enable_mask_test.sv ====
// Purpose: Self-checking bench for the interrupt enable mask register.
// Assumes: 100 MHz clock; inputs change 1 ns after the rising edge.
// Notes: Requests are compared four cycles after a change to cover the pin synchronisers.
module interrupt_enable_mask_test;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_enable_pkg::*;
  logic clk, srst, sfr_wr, sfr_rd, bit_wr, bit_wdata, irq_any;
  logic [7:0] sfr_addr, bit_addr, set_vec, clr_vec, flags_ff;
  sfr_byte_t sfr_wdata, sfr_rdata, irq_enable_mask, rd_val;
  src_vec_t irq_req;
  int err_total = 0;
  int n_checks = 0;

  // ********************
  // Design and sources
  // ********************
  interrupt_enable_mask dut (.clk(clk), .srst(srst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .bit_wr(bit_wr),
    .bit_addr(bit_addr), .bit_wdata(bit_wdata), .irq_enable_mask(irq_enable_mask),
    .spi_port0_irq_flag(flags_ff[7]), .timer2_low_overflow_flag(flags_ff[6]),
    .timer2_high_overflow_flag(flags_ff[5]), .uart_port0_irq_flag(flags_ff[4]),
    .timer1_overflow_flag(flags_ff[3]), .timer0_overflow_flag(flags_ff[2]),
    .external_request1_input(flags_ff[1]), .external_request0_input(flags_ff[0]),
    .irq_req(irq_req), .irq_any(irq_any));
  irq_source_model u_src (.clk(clk), .srst(srst), .set_vec(set_vec), .clr_vec(clr_vec),
    .flags_ff(flags_ff));

  // ********************
  // Tasks
  // ********************
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Strobes drop for a cycle between accesses so no signal is driven twice at one time.
  task automatic wr_byte(input logic [7:0] a, input sfr_byte_t d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask
  task automatic wr_bit(input logic [7:0] a, input logic v);
    bit_addr = a;
    bit_wdata = v;
    bit_wr = 1'b1;
    step(1);
    bit_wr = 1'b0;
    step(1);
  endtask
  task automatic rd_byte(input logic [7:0] a);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    rd_val = sfr_rdata;
    sfr_rd = 1'b0;
    step(1);
  endtask
  task automatic set_flags(input logic [7:0] v);
    set_vec = v;
    clr_vec = ~v;
    step(1);
    set_vec = 8'h00;
    clr_vec = 8'h00;
  endtask
  function automatic logic [7:0] exp_req(input logic [7:0] m, input logic [7:0] f);
    logic [6:0] src;
    src = {f[7], f[6] | f[5], f[4], f[3], f[1], f[2], f[0]};
    return m[7] ? {1'b0, src & m[6:0]} : 8'h00;
  endfunction
  task automatic chk_req(input logic [7:0] m);
    step(4);
    chk({1'b0, irq_req}, exp_req(m, flags_ff));
    chk({7'h00, irq_any}, {7'h00, |exp_req(m, flags_ff)});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ********************
  // Clock, watchdog, tests
  // ********************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The tests need about 140 cycles; this limit only catches a hang.
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  initial
  begin
    {srst, sfr_wr, sfr_rd, bit_wr, bit_wdata} = 5'b10000;
    {sfr_addr, bit_addr, sfr_wdata, set_vec, clr_vec} = 40'h0;
    step(5);
    srst = 1'b0;
    rd_byte(8'hA8);
    chk(rd_val, 8'h00);
    chk(irq_enable_mask, 8'h00);
    wr_byte(8'hA8, 8'hFF);
    wr_byte(8'hA9, 8'h00);
    rd_byte(8'hA8);
    chk(rd_val, 8'hFF);
    rd_byte(8'hA9);
    chk(rd_val, 8'h00);
    chk(irq_enable_mask, 8'hFF);
    // Each source alone, every mask open.
    for (int i = 0; i < 8; i++)
    begin
      set_flags(8'h01 << i);
      chk_req(8'hFF);
    end
    // All sources pending, one mask open at a time, then all masks open with global off and then on.
    set_flags(8'hFF);
    for (int i = 0; i < 7; i++)
    begin
      wr_byte(8'hA8, 8'h80 | (8'h01 << i));
      chk_req(8'h80 | (8'h01 << i));
    end
    wr_byte(8'hA8, 8'h7F);
    chk_req(8'h7F);
    wr_bit(8'hAF, 1'b1);
    chk_req(8'hFF);
    // Bit writes, one of them to another byte that must be ignored.
    wr_byte(8'hA8, 8'h00);
    for (int i = 0; i < 8; i += 2)
      wr_bit(8'hA8 + i[7:0], 1'b1);
    wr_bit(8'hB1, 1'b1);
    wr_bit(8'hAE, 1'b0);
    rd_byte(8'hA8);
    chk(rd_val, 8'h15);
    // A reset in mid-run must bring a fully set register back to zero.
    wr_byte(8'hA8, 8'hFF);
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    rd_byte(8'hA8);
    chk(rd_val, 8'h00);
    chk(irq_enable_mask, 8'h00);
    set_flags(8'hFF);
    chk_req(8'h00);
    tally_and_finish;
  end
endmodule
